//--- verilog/aiu_interrupt_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - seven equal-priority sources drive one active-low pin when unmasked.
// RULE2 - each source sets its status flag regardless of its enable bit.
// RULE3 - reading the status register or a device reset clears all flags.
// RULE4 - the host reads the status register after writing the enable register.
// RULE5 - source 0 fires when either of two watchdog comparisons crosses its limit in its selected sense.
// RULE6 - source 1 fires when the instruction pointer reaches the trigger in enable bits 8-10, before execution.
// RULE7 - with trigger 000 the first fetch of instruction 000 does not fire source 1, later ones do.
// RULE8 - interrupts never stop the sequencer.
// RULE9 - source 2 fires when the fifo count equals the nonzero threshold in enable bits 11-15.
// RULE10 - source 3 fires when the short auto-zero completes.
// RULE11 - source 4 fires when full calibration completes.
// RULE12 - source 5 fires when the sequencer reaches a pause instruction.
// RULE13 - source 7 fires about 10 ms after standby is cleared.
// RULE14 - enable and status bits 0-5 and 7 map to sources 0-5 and 7, bit 6 is don't care.
// RULE15 - status bits 8-10 show the instruction pointer and 11-15 the fifo count while running.
// RULE16 - the pin is low when any enabled flag over bits 0-5 and 7 is set.
module aiu_interrupt_unit
#(
    parameter int WAKE_DELAY_CYC = aiu_pkg::WAKE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        devReset,
    input  wire logic [3:0]  regAddr,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [15:0] regWdata,
    output logic      [15:0] regRdata,
    input  wire logic        wdCompare,
    input  wire logic        wdLimitSel,
    input  wire logic        wdAbove,
    input  wire logic        wdDirBit,
    input  wire logic        instrFetch,
    input  wire logic [2:0]  instructionPointer,
    input  wire logic        pauseFetch,
    input  wire logic        seqRunning,
    input  wire logic [5:0]  fifoCount,
    input  wire logic        fifoWrite,
    input  wire logic        shortCalDone,
    input  wire logic        fullCalDone,
    input  wire logic        standbyBit,
    output logic             intPin_n,
    output logic             wdLimitHit,
    output logic             wdLimitIdx
);
    import aiu_pkg::*;

    // =========================================================
    // register state
    logic [15:0]             mask_r,     mask_nxt;
    logic                    seenZero_r, seenZero_nxt;
    logic [15:0]             rdata_r,    rdata_nxt;
    logic                    pin_r,      pin_nxt;
    logic                    hit_r,      hit_nxt;
    logic                    idx_r,      idx_nxt;
    logic                    stby_r,     stby_nxt;
    aiu_wake_type            wake_r,     wake_nxt;
    logic [WAKE_CNT_W-1:0]   wcnt_r,     wcnt_nxt;
    logic [7:0]              evt;
    logic [7:0]              flags;
    logic [7:0]              req;
    logic                    statusRead;
    logic                    clrAll;
    logic                    wakeDone;
    logic [2:0]              trig;
    logic [4:0]              lvl;

    assign trig       = mask_r[TRIG_MSB:TRIG_LSB];
    assign lvl        = mask_r[LVL_MSB:LVL_LSB];
    assign statusRead = regRd && (regAddr == ADDR_FLAGS_PROG);
    assign clrAll     = statusRead || devReset;                                     // [RULE3]

    // =========================================================
    // event detection; none of these feed back into the sequencer [RULE8]
    always_comb begin
        evt                = 8'h00;
        evt[BIT_WATCHDOG]  = wdCompare && (wdAbove == wdDirBit);                    // [RULE5]
        evt[BIT_IPMATCH]   = instrFetch && (instructionPointer == trig)
                             && ((trig != 3'h0) || seenZero_r);                     // [RULE6] [RULE7]
        evt[BIT_FIFOLVL]   = fifoWrite && (lvl != 5'h00)
                             && (fifoCount == {1'b0, lvl});                         // [RULE9]
        evt[BIT_SHORTCAL]  = shortCalDone;                                          // [RULE10]
        evt[BIT_FULLCAL]   = fullCalDone;                                           // [RULE11]
        evt[BIT_PAUSE]     = instrFetch && pauseFetch;                              // [RULE12]
        evt[BIT_WAKE]      = wakeDone;                                              // [RULE13]
    end

    // =========================================================
    // sticky flags, set regardless of enable
    genvar g;
    generate
        for (g = 0; g < SRC_COUNT; g++) begin : gFlag
            aiu_flag uFlag (
                .clk     (clk),
                .rstn    (rstn),
                .setEvt  (evt[g] && SRC_PIN_MASK[g]),                               // [RULE2] [RULE14]
                .clrFlag (clrAll),
                .enable  (mask_r[g] && SRC_PIN_MASK[g]),                            // [RULE14]
                .flag    (flags[g]),
                .request (req[g])
            );
        end
    endgenerate

    // =========================================================
    // standby wake timer
    assign wakeDone = (wake_r == WAKE_WAIT) && (wcnt_r == WAKE_CNT_W'(WAKE_DELAY_CYC - 1));

    always_comb begin
        wake_nxt = wake_r;
        wcnt_nxt = wcnt_r;
        stby_nxt = standbyBit;
        case (wake_r)
            WAKE_IDLE: begin
                if (stby_r && !standbyBit) begin                                    // [RULE13]
                    wake_nxt = WAKE_WAIT;
                    wcnt_nxt = '0;
                end
            end
            WAKE_WAIT: begin
                if (standbyBit || wakeDone) begin
                    wake_nxt = WAKE_IDLE;
                end else begin
                    wcnt_nxt = wcnt_r + 1'b1;
                end
            end
            default: wake_nxt = WAKE_IDLE;
        endcase
    end

    // =========================================================
    // registers, read path, pin
    always_comb begin
        mask_nxt     = mask_r;
        seenZero_nxt = seenZero_r;
        rdata_nxt    = rdata_r;
        hit_nxt      = 1'b0;
        idx_nxt      = idx_r;
        if (regWr && (regAddr == ADDR_MASK_TRIG)) begin
            mask_nxt = regWdata;
        end
        if (devReset) begin
            seenZero_nxt = 1'b0;
        end else if (instrFetch && (instructionPointer == 3'h0)) begin
            seenZero_nxt = 1'b1;                                                    // [RULE7]
        end
        if (evt[BIT_WATCHDOG]) begin
            hit_nxt = 1'b1;
            idx_nxt = wdLimitSel;                                                   // [RULE5]
        end
        if (regRd) begin
            case (regAddr)
                ADDR_MASK_TRIG:  rdata_nxt = mask_r;
                ADDR_FLAGS_PROG: rdata_nxt = seqRunning ?
                                     {fifoCount[4:0], instructionPointer, flags} :  // [RULE15]
                                     {8'h00, flags};
                default:         rdata_nxt = 16'h0000;
            endcase
        end
        pin_nxt = ~|req;                                                            // [RULE1] [RULE16]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_r     <= MASK_RST;
            seenZero_r <= 1'b0;
            rdata_r    <= 16'h0000;
            pin_r      <= 1'b1;
            hit_r      <= 1'b0;
            idx_r      <= 1'b0;
            stby_r     <= 1'b0;
            wake_r     <= WAKE_IDLE;
            wcnt_r     <= '0;
        end else begin
            mask_r     <= mask_nxt;
            seenZero_r <= seenZero_nxt;
            rdata_r    <= rdata_nxt;
            pin_r      <= pin_nxt;
            hit_r      <= hit_nxt;
            idx_r      <= idx_nxt;
            stby_r     <= stby_nxt;
            wake_r     <= wake_nxt;
            wcnt_r     <= wcnt_nxt;
        end
    end

    assign regRdata   = rdata_r;
    assign intPin_n   = pin_r;
    assign wdLimitHit = hit_r;
    assign wdLimitIdx = idx_r;

    // =========================================================
    // assertion helper: cycles since standby went low
    logic [WAKE_CNT_W-1:0]   lowCnt_r,   lowCnt_nxt;

    always_comb begin
        lowCnt_nxt = lowCnt_r;
        if (standbyBit) begin
            lowCnt_nxt = '0;
        end else if (lowCnt_r != '1) begin
            lowCnt_nxt = lowCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lowCnt_r <= '0;
        end else begin
            lowCnt_r <= lowCnt_nxt;
        end
    end

    // =========================================================
    // assertions
    sequence s_pend;
        |(flags & mask_r[7:0] & SRC_PIN_MASK);
    endsequence

    a_pin_follows: assert property (@(posedge clk) disable iff (!rstn)          // [RULE16]
        s_pend |=> !intPin_n) else $error("pin not low with pending source");
    a_pin_idle: assert property (@(posedge clk) disable iff (!rstn)             // [RULE1]
        !(|(flags & mask_r[7:0] & SRC_PIN_MASK)) |=> intPin_n) else $error("pin low with nothing pending");
    a_read_clears: assert property (@(posedge clk) disable iff (!rstn)          // [RULE3]
        (clrAll && !(|evt)) |=> (flags == 8'h00)) else $error("flags not cleared");
    a_set_unmasked: assert property (@(posedge clk) disable iff (!rstn)         // [RULE2]
        (evt[BIT_SHORTCAL] && !mask_r[BIT_SHORTCAL]) |=> flags[BIT_SHORTCAL]) else $error("flag not set");
    a_bit6_quiet: assert property (@(posedge clk) disable iff (!rstn)           // [RULE14]
        flags[BIT_UNUSED] == 1'b0) else $error("bit 6 flag set");
    a_zero_first: assert property (@(posedge clk) disable iff (!rstn)           // [RULE7]
        (instrFetch && instructionPointer == 3'h0 && trig == 3'h0 && !seenZero_r)
        |-> !evt[BIT_IPMATCH]) else $error("first fetch of 0 flagged");
    a_fifo_match: assert property (@(posedge clk) disable iff (!rstn)           // [RULE9]
        (fifoWrite && lvl != 5'h00 && fifoCount == {1'b0, lvl}) |=> flags[BIT_FIFOLVL])
        else $error("fifo level flag missing");
    a_wake_delay: assert property (@(posedge clk) disable iff (!rstn)           // [RULE13]
        evt[BIT_WAKE] |-> (lowCnt_r == WAKE_CNT_W'(WAKE_DELAY_CYC)))
        else $error("wake flag off its settling delay");
endmodule : aiu_interrupt_unit

//--- verilog/aiu_pkg.sv
package aiu_pkg;
    // =========================================================
    // register addresses (A4-A1 word index)
    localparam logic [3:0]  ADDR_MASK_TRIG   = 4'h9;
    localparam logic [3:0]  ADDR_FLAGS_PROG  = 4'ha;
    // =========================================================
    // field positions
    localparam int          SRC_COUNT        = 8;
    localparam int          BIT_WATCHDOG     = 0;
    localparam int          BIT_IPMATCH      = 1;
    localparam int          BIT_FIFOLVL      = 2;
    localparam int          BIT_SHORTCAL     = 3;
    localparam int          BIT_FULLCAL      = 4;
    localparam int          BIT_PAUSE        = 5;
    localparam int          BIT_UNUSED       = 6;
    localparam int          BIT_WAKE         = 7;
    localparam int          TRIG_LSB         = 8;
    localparam int          TRIG_MSB         = 10;
    localparam int          LVL_LSB          = 11;
    localparam int          LVL_MSB          = 15;
    localparam logic [7:0]  SRC_PIN_MASK     = 8'hbf;
    // =========================================================
    // reset values
    localparam logic [15:0] MASK_RST         = 16'h0000;
    localparam logic [7:0]  FLAGS_RST        = 8'h00;
    // =========================================================
    // timing
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          WAKE_DELAY_MS    = 10;
    localparam int          WAKE_CYCLES      = (WAKE_DELAY_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          WAKE_CNT_W       = 24;
    typedef enum logic [0:0] {
        WAKE_IDLE = 1'b0,
        WAKE_WAIT = 1'b1
    } aiu_wake_type;
endpackage : aiu_pkg

//--- verilog/aiu_flag.sv
`timescale 1ns/1ps
// =========================================================
// one sticky status flag with gated pin request
module aiu_flag (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic setEvt,
    input  wire logic clrFlag,
    input  wire logic enable,
    output logic      flag,
    output logic      request
);
    logic flag_r;
    logic flag_nxt;

    always_comb begin
        flag_nxt = flag_r;
        if (clrFlag) begin
            flag_nxt = 1'b0;
        end
        if (setEvt) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag    = flag_r;
    assign request = flag_r & enable;
endmodule : aiu_flag

//--- testbench/aiu_host_model.sv
`timescale 1ns/1ps
// =========================================================
// host side of the register bus, one-cycle strobes
module aiu_host_model (
    input  wire logic        clk,
    output logic      [3:0]  regAddr,
    output logic             regWr,
    output logic             regRd,
    output logic      [15:0] regWdata
);
    import aiu_pkg::*;
    initial begin
        regAddr  = 4'h0;
        regWr    = 1'b0;
        regRd    = 1'b0;
        regWdata = 16'h0000;
    end
    // released lines show the inverse, never the stale value
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        regAddr  = a;
        regWdata = d;
        regWr    = wr;
        regRd    = ~wr;
        @(posedge clk);
        #1;
        regWr    = 1'b0;
        regRd    = 1'b0;
        regAddr  = ~a;
        regWdata = ~d;
    endtask : xfer
    task automatic rd(input logic [3:0] a);
        xfer(1'b0, a, 16'h0000);
    endtask : rd
    task automatic setMask(input logic [15:0] v);
        xfer(1'b1, ADDR_MASK_TRIG, v);
        rd(ADDR_FLAGS_PROG);
    endtask : setMask
endmodule : aiu_host_model

//--- testbench/aiu_interrupt_unit_tb.sv
`timescale 1ns/1ps
module aiu_interrupt_unit_tb import aiu_pkg::*;;
    logic        clk = 0, rstn = 0, devReset = 0, wdCompare = 0, wdLimitSel = 0, wdAbove = 0, wdDirBit = 0;
    logic        instrFetch = 0, pauseFetch = 0, seqRunning = 0, fifoWrite = 0, shortCalDone = 0;
    logic        fullCalDone = 0, standbyBit = 0, regWr, regRd, intPin_n, rdTaken = 0, wdLimitHit, wdLimitIdx;
    logic [2:0]  instructionPointer = 0, trig;
    logic [5:0]  fifoCount = 0;
    logic [4:0]  lvl;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata;
    logic [15:0] expQ[$];
    int          errorCnt = 0, checked = 0, seed = 80;
    logic        dir;
    initial forever #5 clk = ~clk;
    aiu_host_model i_host (.clk(clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata));
    aiu_interrupt_unit #(.WAKE_DELAY_CYC(20)) i_dut (
        .clk(clk), .rstn(rstn), .devReset(devReset), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWdata(regWdata), .regRdata(regRdata), .wdCompare(wdCompare), .wdLimitSel(wdLimitSel),
        .wdAbove(wdAbove), .wdDirBit(wdDirBit), .instrFetch(instrFetch),
        .instructionPointer(instructionPointer), .pauseFetch(pauseFetch), .seqRunning(seqRunning),
        .fifoCount(fifoCount), .fifoWrite(fifoWrite), .shortCalDone(shortCalDone),
        .fullCalDone(fullCalDone), .standbyBit(standbyBit), .intPin_n(intPin_n),
        .wdLimitHit(wdLimitHit), .wdLimitIdx(wdLimitIdx));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            errorCnt++;
        end
    endtask : check
    task automatic stopTest();
        if (errorCnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stopTest
    // =========================================================
    // monitor: each read answer against the oldest note
    always @(posedge clk) rdTaken <= regRd & rstn;
    always @(negedge clk) begin
        if (rdTaken) begin
            check(regRdata, expQ.pop_front());
        end
    end
    task automatic rdExp(input logic [3:0] a, input logic [15:0] e);
        expQ.push_back(e);
        i_host.rd(a);
    endtask : rdExp
    task automatic setMask(input logic [15:0] v);
        expQ.push_back(16'h0000);
        i_host.setMask(v);
        rdExp(ADDR_MASK_TRIG, v);
    endtask : setMask
    task automatic fire(input int s);
        case (s)
            0: begin
                wdCompare  = 1;
                wdLimitSel = seed[0];
                wdDirBit   = dir;
                wdAbove    = dir;
            end
            1: begin
                instrFetch         = 1;
                instructionPointer = trig;
            end
            2: begin
                fifoWrite = 1;
                fifoCount = {1'b0, lvl};
            end
            3: shortCalDone = 1;
            4: fullCalDone = 1;
            5: begin
                instrFetch         = 1;
                pauseFetch         = 1;
                instructionPointer = trig + 3'h1;
            end
            default: standbyBit = 1;
        endcase
        @(posedge clk);
        #1;
        if (s == 0) begin
            check(16'(wdLimitHit), 16'h0001);
            check(16'(wdLimitIdx), 16'(wdLimitSel));
        end
        {wdCompare, instrFetch, pauseFetch, fifoWrite, shortCalDone, fullCalDone, standbyBit} = 7'h00;
        repeat (30) @(posedge clk);
        #1;
    endtask : fire
    task automatic pulseReset();
        devReset = 1;
        @(posedge clk);
        #1;
        devReset = 0;
    endtask : pulseReset
    initial begin
        #200000;
        errorCnt++;
        stopTest();
    end
    // =========================================================
    // main sequence
    initial begin
        dir  = 1'($random(seed));
        trig = 3'(($random(seed) & 32'h3) + 1);
        lvl  = 5'(($random(seed) & 32'hf) + 1);
        repeat (6) @(posedge clk);
        #1;
        rstn = 1;
        rdExp(ADDR_MASK_TRIG, MASK_RST);
        rdExp(ADDR_FLAGS_PROG, 16'h0000);
        rdExp(4'h3, 16'h0000);
        check(16'(intPin_n), 16'h0001);
        for (int s = 0; s < SRC_COUNT; s++) begin
            if (SRC_PIN_MASK[s]) begin
                setMask({lvl, trig, 8'(1 << s)});
                fire(s);
                check(16'(intPin_n), 16'h0000);
                rdExp(ADDR_FLAGS_PROG, 16'(1 << s));
                repeat (3) @(posedge clk);
                #1;
                check(16'(intPin_n), 16'h0001);
            end
        end
        setMask(16'h0000);
        fire(3);
        check(16'(intPin_n), 16'h0001);
        rdExp(ADDR_FLAGS_PROG, 16'h0008);
        fire(4);
        pulseReset();
        rdExp(ADDR_FLAGS_PROG, 16'h0000);
        trig = 3'h0;
        setMask(16'h0002);
        fire(1);
        rdExp(ADDR_FLAGS_PROG, 16'h0000);
        fire(1);
        rdExp(ADDR_FLAGS_PROG, 16'h0002);
        lvl = 5'h00;
        setMask(16'h0004);
        fire(2);
        rdExp(ADDR_FLAGS_PROG, 16'h0000);
        wdAbove   = ~dir;
        wdCompare = 1;
        @(posedge clk);
        #1;
        check(16'(wdLimitHit), 16'h0000);
        wdCompare = 0;
        rdExp(ADDR_FLAGS_PROG, 16'h0000);
        seqRunning = 1;
        instructionPointer = 3'h6;
        fifoCount = 6'h0a;
        rdExp(ADDR_FLAGS_PROG, {5'h0a, 3'h6, 8'h00});
        seqRunning = 0;
        repeat (3) @(posedge clk);
        stopTest();
    end
endmodule : aiu_interrupt_unit_tb
